// ==== logic/prr_top.sv ====
// Peripheral reset command, address 0 remap and external reset gate.
// Holds the command decode, the reset pulse, the mapping register, the
// pin enable and the registered read path, with their checks.
// Assumes a single-cycle memory bus on the system clock and an external
// reset pin from outside the clock domain.
// Assumes a debugger on the far side that writes keyed 32-bit words.
`timescale 1ns/1ps
`include "prr_defines.svh"

// Behaviour
// - The external reset pin is ignored until software enables it.
// - Writing the peripheral reset bit with the key to the command word resets peripherals.
// - The peripheral reset also restores flash at address 0.
// - Address 0 holds flash or RAM, flash after any reset.
// - Each remap write with bit zero set outside a reset pulse toggles the address 0 mapping.
module prr_top (
   input  wire logic              SYS_CLK_I,
   input  wire logic              SYS_RST_I,
   input  wire prr_pkg::prr_bus_s BUS_I,
   output logic [31:0]            RDATA_O,
   input  wire logic              EXT_RST_N_I,
   output logic                   PERIPH_RST_O,
   output logic                   MAP_RAM_O
);
   import prr_pkg::*;

   prr_map_e   map;
   logic       ext_en;
   logic [3:0] pulse_cnt;
   logic       ext_s1;
   logic       ext_s2;
   logic       wr_cmd;
   logic       wr_remap;
   logic       wr_ext;
   logic       key_ok;
   logic       ext_hit;
   logic       pulse_start;

   // ****************************************
   // Bus decode
   // ****************************************
   assign key_ok   = BUS_I.wdata[`PRR_KEY_MSB:`PRR_KEY_LSB] == `PRR_KEY;
   assign wr_cmd   = BUS_I.wr && (BUS_I.addr == `PRR_RESET_CMD_ADDR);
   assign wr_remap = BUS_I.wr && (BUS_I.addr == `PRR_REMAP_ADDR);
   assign wr_ext   = BUS_I.wr && (BUS_I.addr == `PRR_EXTRST_ADDR);
   assign ext_hit  = ext_en && !ext_s2;

   // Pulse start from a keyed command or the enabled pin
   assign pulse_start = (wr_cmd && key_ok && BUS_I.wdata[`PRR_PERRST_BIT])
                        || ext_hit;

   // ****************************************
   // Pin synchroniser
   // ****************************************
   // Two stages, first stage read only by second
   always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         ext_s1 <= 1'b1;
         ext_s2 <= 1'b1;
      end else begin
         ext_s1 <= EXT_RST_N_I;
         ext_s2 <= ext_s1;
      end
   end

   // ****************************************
   // Pin enable
   // ****************************************
   // External reset enable, off after reset
   always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         ext_en <= 1'b0;
      end else if (PERIPH_RST_O) begin
         ext_en <= 1'b0;
      end else if (wr_ext) begin
         ext_en <= BUS_I.wdata[`PRR_EXTRST_EN_BIT];
      end
   end

   // ****************************************
   // Peripheral reset pulse
   // ****************************************
   // Reload on every start, so a new command restarts the pulse
   always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         pulse_cnt <= 4'h0;
      end else if (pulse_start) begin
         pulse_cnt <= `PRR_PULSE_CYCLES;
      end else if (pulse_cnt != 4'h0) begin
         pulse_cnt <= pulse_cnt - 4'h1;
      end
   end
   assign PERIPH_RST_O = pulse_cnt != 4'h0;

   // ****************************************
   // Address 0 mapping
   // ****************************************
   // Flash after any reset, toggled by remap writes with bit zero set
   always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         map <= PRR_MAP_FLASH;
      end else if (PERIPH_RST_O) begin
         map <= PRR_MAP_FLASH;
      end else if (wr_remap && BUS_I.wdata[`PRR_REMAP_BIT]) begin
         case (map)
            PRR_MAP_FLASH: map <= PRR_MAP_RAM;
            PRR_MAP_RAM:   map <= PRR_MAP_FLASH;
            default:       map <= PRR_MAP_FLASH;
         endcase
      end
   end
   assign MAP_RAM_O = map == PRR_MAP_RAM;

   // ****************************************
   // Read path
   // ****************************************
   // Read data, command word reads zero
   always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         RDATA_O <= 32'h0;
      end else if (BUS_I.rd && BUS_I.addr == `PRR_EXTRST_ADDR) begin
         RDATA_O <= {31'h0, ext_en};
      end else if (BUS_I.rd && BUS_I.addr == `PRR_STATUS_ADDR) begin
         RDATA_O <= {30'h0, PERIPH_RST_O, MAP_RAM_O};
      end else begin
         RDATA_O <= 32'h0;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (SYS_RST_I);

   // Keyed command with the peripheral reset bit
   sequence s_cmd;
      wr_cmd && key_ok && BUS_I.wdata[`PRR_PERRST_BIT];
   endsequence

   // Four cycles in which nothing restarts the pulse
   sequence s_no_restart;
      (!pulse_start)[*4];
   endsequence

   // Command followed by a quiet stretch
   sequence s_cmd_settled;
      s_cmd ##1 s_no_restart;
   endsequence

   // Enabled pin seen low through both stages
   sequence s_pin_seen;
      ext_en && !ext_s2;
   endsequence

   // Remap write asking for a toggle, outside a reset pulse
   sequence s_remap_set;
      wr_remap && BUS_I.wdata[`PRR_REMAP_BIT] && !PERIPH_RST_O;
   endsequence

   // Pin gate and pin enable register
   a_ext_gated: assert property (!ext_en && !wr_cmd |=>
      $stable(pulse_cnt) || pulse_cnt == $past(pulse_cnt) - 4'h1)
      else $error("reset pulse started while pin disabled");

   a_pin_pulse: assert property (s_pin_seen |=> PERIPH_RST_O)
      else $error("enabled pin low did not reset peripherals");

   a_ext_write: assert property (wr_ext && !PERIPH_RST_O |=>
      ext_en == $past(BUS_I.wdata[`PRR_EXTRST_EN_BIT]))
      else $error("pin enable write not taken");

   a_ext_clear: assert property (PERIPH_RST_O |=> !ext_en)
      else $error("pin enable survived peripheral reset");

   // Peripheral reset pulse length and refusals
   a_cmd_pulse: assert property (s_cmd |=> PERIPH_RST_O[*4])
      else $error("peripheral reset pulse too short");

   a_pulse_end: assert property (s_cmd_settled |=> !PERIPH_RST_O)
      else $error("peripheral reset pulse too long");

   a_cmd_nokey: assert property (wr_cmd && !key_ok && !ext_hit
      && pulse_cnt == 4'h0 |=> !PERIPH_RST_O)
      else $error("unkeyed command reset peripherals");

   a_cmd_nobit: assert property (wr_cmd && key_ok
      && !BUS_I.wdata[`PRR_PERRST_BIT] && !ext_hit && pulse_cnt == 4'h0
      |=> !PERIPH_RST_O)
      else $error("command without reset bit reset peripherals");

   // Address 0 mapping
   a_rst_flash: assert property (PERIPH_RST_O |=> !MAP_RAM_O)
      else $error("flash not restored by peripheral reset");

   a_map_onehot: assert property ($onehot(map))
      else $error("mapping not one-hot");

   a_remap_toggle: assert property (s_remap_set |=>
      MAP_RAM_O != $past(MAP_RAM_O))
      else $error("remap did not toggle");

   a_remap_hold: assert property (wr_remap && !BUS_I.wdata[0]
      && !PERIPH_RST_O |=> $stable(MAP_RAM_O))
      else $error("remap changed with bit zero clear");

   // Registered read path
   a_rd_idle: assert property (!BUS_I.rd |=> RDATA_O == 32'h0)
      else $error("read data not zero without a read");

   a_rd_cmd: assert property (BUS_I.rd
      && BUS_I.addr == `PRR_RESET_CMD_ADDR |=> RDATA_O == 32'h0)
      else $error("command word did not read zero");

   a_rd_status: assert property (BUS_I.rd
      && BUS_I.addr == `PRR_STATUS_ADDR |=>
      RDATA_O == {30'h0, $past(PERIPH_RST_O), $past(MAP_RAM_O)})
      else $error("status read does not match the state");

   a_rd_enable: assert property (BUS_I.rd
      && BUS_I.addr == `PRR_EXTRST_ADDR |=>
      RDATA_O == {31'h0, $past(ext_en)})
      else $error("pin enable read does not match");
endmodule

// ==== include/prr_defines.svh ====
// Constants for the peripheral reset and remap block.
// Assumes inclusion by bare name from the design files.
`ifndef PRR_DEFINES_SVH
`define PRR_DEFINES_SVH
`define PRR_RESET_CMD_ADDR  32'hfffffd00
`define PRR_REMAP_ADDR      32'hfffffd04
`define PRR_EXTRST_ADDR     32'hfffffd08
`define PRR_STATUS_ADDR     32'hfffffd0c
`define PRR_KEY             8'ha5
`define PRR_KEY_MSB         31
`define PRR_KEY_LSB         24
`define PRR_PERRST_BIT      2
`define PRR_REMAP_BIT       0
`define PRR_EXTRST_EN_BIT   0
`define PRR_PULSE_CYCLES    4'h4
`define PRR_CMD_WORD        32'ha5000004
`define PRR_WDOG_ADDR       32'hfffffd44
`define PRR_WDOG_OFF        32'h00008000
`define PRR_CLKSRC_ADDR     32'hfffffc20
`define PRR_CLKSRC_WORD     32'h00000601
`define PRR_PLL_ADDR        32'hfffffc2c
`define PRR_MCLK_ADDR       32'hfffffc30
`define PRR_MCLK_WORD       32'h00000007
`define PRR_FLASHWS_ADDR    32'hffffff60
`define PRR_FLASHWS_WORD    32'h002f0100
`endif

// ==== include/prr_pkg.sv ====
// Types for the peripheral reset and remap block.
// Assumes no other package.
package prr_pkg;
   typedef enum logic [1:0] {
      PRR_MAP_FLASH = 2'b01,
      PRR_MAP_RAM   = 2'b10
   } prr_map_e;
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [31:0] addr;
      logic [31:0] wdata;
   } prr_bus_s;
endpackage

// ==== dv/prr_probe.sv ====
// Debug probe model issuing single 32-bit target reads and writes.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ps
`include "prr_defines.svh"
module prr_probe #(
   parameter logic [31:0] PLL_WORD = 32'h10191c05, // Any divider setting
   parameter int          SLOW_GAP = 10            // Pause of the slow link
) (
   input  wire logic         clk_i,
   input  wire logic [31:0]  rdata_i,
   output prr_pkg::prr_bus_s bus_o
);
   import prr_pkg::*;
   initial bus_o = '0;
   // Hold the word up to the taking edge, then scramble the released bus
   task automatic put(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk_i);
      bus_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk_i);
      bus_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
      #1;
   endtask
   // Read one word, taken on the registered answer after the request
   task automatic get(input logic [31:0] a, output logic [31:0] d);
      @(posedge clk_i);
      bus_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      @(posedge clk_i);
      bus_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 32'h0};
      #1 d = rdata_i;
   endtask
   // Watchdog off, clock setup and flash wait state, slow link pauses
   task automatic setup;
      put(`PRR_WDOG_ADDR, `PRR_WDOG_OFF);
      repeat (SLOW_GAP) @(posedge clk_i);
      put(`PRR_CLKSRC_ADDR, `PRR_CLKSRC_WORD);
      repeat (SLOW_GAP) @(posedge clk_i);
      put(`PRR_PLL_ADDR, PLL_WORD);
      repeat (SLOW_GAP) @(posedge clk_i);
      put(`PRR_MCLK_ADDR, `PRR_MCLK_WORD);
      repeat (SLOW_GAP) @(posedge clk_i);
      put(`PRR_FLASHWS_ADDR, `PRR_FLASHWS_WORD);
      repeat (SLOW_GAP) @(posedge clk_i);
      #1;
   endtask
endmodule

// ==== dv/peripheral_reset_and_remap_bench.sv ====
// Bench for the peripheral reset and remap block.
// Assumes the probe model drives the bus and the defines header is found.
`timescale 1ns/1ps
`include "prr_defines.svh"
module peripheral_reset_and_remap_bench;
   import prr_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        ext_n = 1'b1;
   prr_bus_s    bus;
   logic [31:0] rdata;
   logic [31:0] rd_val;
   logic        prst;
   logic        map;
   int          fail_count = 0;
   int          n_tests = 0;
   int          pulses = 0;
   int          n = 0;
   always #10 clk = ~clk;
   prr_top i_prr_top (.SYS_CLK_I(clk), .SYS_RST_I(rst), .BUS_I(bus),
      .RDATA_O(rdata), .EXT_RST_N_I(ext_n), .PERIPH_RST_O(prst),
      .MAP_RAM_O(map));
   prr_probe i_prr_probe (.clk_i(clk), .rdata_i(rdata), .bus_o(bus));
   // Count peripheral reset pulses
   always @(posedge prst) pulses++;
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         fail_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Pin low long enough for sync and a full pulse
   task automatic pin_low;
      @(posedge clk);
      ext_n <= 1'b0;
      repeat (8) @(posedge clk);
      ext_n <= 1'b1;
      repeat (6) @(posedge clk);
      #1;
   endtask
   // Watchdog
   initial begin
      #20000;
      fail_count++;
      summarize();
   end
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      #1 chk(map, 0);
      i_prr_probe.put(`PRR_REMAP_ADDR, 32'h1);
      chk(map, 1);
      i_prr_probe.put(`PRR_REMAP_ADDR, 32'h2);
      chk(map, 1);
      i_prr_probe.get(`PRR_STATUS_ADDR, rd_val);
      chk(rd_val, 32'h1);
      i_prr_probe.put(`PRR_REMAP_ADDR, 32'h1);
      chk(map, 0);
      i_prr_probe.put(`PRR_REMAP_ADDR, 32'h1);
      chk(map, 1);
      $display("remap test done");
      i_prr_probe.put(`PRR_RESET_CMD_ADDR, 32'h5a000004);
      chk(pulses, 0);
      i_prr_probe.put(`PRR_RESET_CMD_ADDR, 32'ha5000000);
      chk(pulses, 0);
      i_prr_probe.put(`PRR_RESET_CMD_ADDR, `PRR_CMD_WORD);
      chk(prst, 1);
      while (prst === 1'b1 && n < 9) begin
         @(posedge clk);
         #1 n++;
      end
      chk(n, 4);
      chk(map, 0);
      chk(pulses, 1);
      i_prr_probe.get(`PRR_RESET_CMD_ADDR, rd_val);
      chk(rd_val, 32'h0);
      $display("command test done");
      pin_low();
      chk(pulses, 1);
      i_prr_probe.put(`PRR_EXTRST_ADDR, 32'h1);
      i_prr_probe.get(`PRR_EXTRST_ADDR, rd_val);
      chk(rd_val, 32'h1);
      pin_low();
      chk(pulses, 2);
      i_prr_probe.get(`PRR_EXTRST_ADDR, rd_val);
      chk(rd_val, 32'h0);
      $display("pin test done");
      // Bring-up in the debugger's order after a system reset, which maps flash back over the RAM left at 0
      i_prr_probe.put(`PRR_REMAP_ADDR, 32'h1);
      chk(map, 1);
      @(posedge clk);
      rst <= 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      #1 chk(map, 0);
      i_prr_probe.put(`PRR_RESET_CMD_ADDR, `PRR_CMD_WORD);
      chk(prst, 1);
      i_prr_probe.setup();
      chk(map, 0);
      chk(pulses, 3);
      i_prr_probe.get(`PRR_STATUS_ADDR, rd_val);
      chk(rd_val, 32'h0);
      $display("bring-up test done");
      summarize();
   end
endmodule
